// ==== inc/sadc_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// Serial link between host and converter
interface sadc_if;
   logic sclk;          // Link clock made by host
   logic cs_n;          // Chip select, active low
   logic serial_in_line;
   logic dout;          // Device data out value
   logic dout_oe_n;     // Device output enable, low while driving
   logic lsb_shift_enable;
   logic conversion_active_flag;
   modport host (output sclk, output cs_n, output serial_in_line, output lsb_shift_enable,
                 input dout, input dout_oe_n, input conversion_active_flag);
   modport dev  (input sclk, input cs_n, input serial_in_line, input lsb_shift_enable,
                 output dout, output dout_oe_n, output conversion_active_flag);
endinterface
`default_nettype wire

// ==== inc/sadc_pkg.sv ====
package sadc_pkg;
   // Channel-count variants
   localparam int unsigned CH1 = 1;
   localparam int unsigned CH2 = 2;
   localparam int unsigned CH4 = 4;
   localparam int unsigned CH8 = 8;
   // Result width and conversion length in link clock periods
   localparam int unsigned RES_W = 8;
   localparam int unsigned CNT_W = 4;
   localparam logic [3:0] LAST_BIT = 4'h7;
   // Host clock: 100 MHz system clock, link clock derived by divider
   localparam int unsigned CLK_MHZ = 100;
   localparam int unsigned LINK_HALF_NS = 500;
   localparam int unsigned LINK_HALF_CYC = (LINK_HALF_NS * CLK_MHZ + 999) / 1000;
   // Deselect time before the host may select again
   localparam int unsigned IDLE_CLEAR_NS = 250;
   localparam int unsigned IDLE_CLEAR_CYC = (IDLE_CLEAR_NS * CLK_MHZ + 999) / 1000;
   // Cleared value of the address word register, loaded at deselect
   localparam logic [3:0] ZERO4 = 4'h0;
endpackage

// ==== logic/sadc_dev.sv ====
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Host holds select low whole conversion
// - Sample input on rising edges while addressing
// - First high bit is start bit
// - Two to four address bits follow start
// - Half-clock settle, flag high, input ignored
// - Output drives leading low in settling slot
// - Result MSB first on falling edges
// - Eight periods; flag drops half clock later
// - Result copied into output shift register
// - Shift enable high holds LSB; low shifts
// - Without shift enable, LSB-first follows automatically
// - After last bit output low until deselect
// - Single-channel variant sends MSB first only
// - Deselect clears all internal registers
// - Each conversion needs new select and start
// - Input sampled only while output released
// - Latest address word sets configuration
// - Eight-channel differential pair and polarity decode
// - Four-channel single-ended and differential decode
// - Single-ended negative is common input
// - Two-channel word: mode and parity bits
// - Eight-channel single-ended channel is 2*sel+odd
// - Single-channel takes no address bits
module sadc_dev #(
   parameter int unsigned CHANNELS  = sadc_pkg::CH8,
   parameter bit          HAS_SE    = 1'b1
) (
   // Link
   sadc_if.dev                 link,
   // Analog side
   input  wire logic [7:0]     comparator_in,
   output logic      [2:0]     pos_channel,
   output logic      [2:0]     neg_channel,
   output logic                neg_is_common,
   output logic      [7:0]     result
);
   localparam int unsigned AW = (CHANNELS == sadc_pkg::CH8) ? 4 :
                                (CHANNELS == sadc_pkg::CH4) ? 3 :
                                (CHANNELS == sadc_pkg::CH2) ? 2 : 0;

   initial begin
      if (CHANNELS != sadc_pkg::CH1 && CHANNELS != sadc_pkg::CH2 &&
          CHANNELS != sadc_pkg::CH4 && CHANNELS != sadc_pkg::CH8)
         $error("sadc_dev: CHANNELS must be 1, 2, 4 or 8");
   end

   typedef enum logic [2:0] {S_WAIT, S_ADDR, S_CONV, S_LSB, S_DONE} sadc_state_e;

   sadc_state_e  state_reg;
   logic [3:0]   addr_reg;     // Address bits after start
   logic [2:0]   addr_cnt_reg;
   logic [3:0]   bit_cnt_reg;
   logic [7:0]   sar_reg;
   logic [7:0]   shift_reg;
   logic         active_reg;
   logic         dout_reg;
   logic         oe_n_reg;

   // Select acts as asynchronous clear of the whole device
   wire          clr = link.cs_n;
   wire [2:0]    aw_w = 3'(AW);
   wire          addr_full = (addr_cnt_reg == aw_w);
   wire          single_w;
   wire          odd_w;
   wire [1:0]    sel_w;
   wire          cmp_bit = comparator_in[3'(4'h7 - bit_cnt_reg)];
   wire [7:0]    sar_next = sar_reg | ({7'h00, cmp_bit} << (4'h7 - bit_cnt_reg));

   // Field decode of latest address word
   assign single_w = (AW >= 2) ? addr_reg[AW-1] : 1'b0;
   assign odd_w    = (AW >= 2) ? addr_reg[AW-2] : 1'b0;
   assign sel_w    = (AW == 4) ? addr_reg[1:0] : (AW == 3) ? {1'b0, addr_reg[0]} : 2'h0;

   // Channel mux decode
   always_comb begin
      pos_channel   = 3'h0;
      neg_channel   = 3'h1;
      neg_is_common = 1'b0;
      if (AW == 0) begin
         pos_channel = 3'h0;
         neg_channel = 3'h1;
      end else if (single_w) begin
         pos_channel   = {sel_w, odd_w};
         neg_is_common = 1'b1;
      end else begin
         pos_channel = {sel_w, odd_w};
         neg_channel = {sel_w, ~odd_w};
      end
   end

   // Rising edge: address capture and successive approximation
   always_ff @(posedge link.sclk or posedge clr) begin
      if (clr) begin
         state_reg    <= S_WAIT;
         addr_reg     <= sadc_pkg::ZERO4;
         addr_cnt_reg <= 3'h0;
         bit_cnt_reg  <= 4'h0;
         sar_reg      <= 8'h00;
         shift_reg    <= 8'h00;
      end else begin
         case (state_reg)
            S_WAIT: begin
               if (link.serial_in_line) begin
                  state_reg <= (AW == 0) ? S_CONV : S_ADDR;
               end
            end
            S_ADDR: begin
               addr_reg     <= {addr_reg[2:0], link.serial_in_line};
               addr_cnt_reg <= addr_cnt_reg + 3'h1;
               if (addr_cnt_reg == aw_w - 3'h1) state_reg <= S_CONV;
            end
            S_CONV: begin
               if (!addr_full && AW != 0) begin
                  state_reg <= S_CONV;
               end
               sar_reg     <= sar_next;
               bit_cnt_reg <= bit_cnt_reg + 4'h1;
               if (bit_cnt_reg == sadc_pkg::LAST_BIT) begin
                  shift_reg <= sar_next;
                  state_reg <= (CHANNELS == sadc_pkg::CH1) ? S_DONE : S_LSB;
               end
            end
            S_LSB: begin
               if (!HAS_SE || !link.lsb_shift_enable) begin
                  shift_reg   <= {1'b0, shift_reg[7:1]};
                  bit_cnt_reg <= bit_cnt_reg - 4'h1;
                  if (bit_cnt_reg == 4'h1) state_reg <= S_DONE;
               end
            end
            S_DONE:  state_reg <= S_DONE;
            default: state_reg <= S_WAIT;
         endcase
      end
   end

   // Falling edge: output data, enable and active flag
   always_ff @(negedge link.sclk or posedge clr) begin
      if (clr) begin
         dout_reg   <= 1'b0;
         oe_n_reg   <= 1'b1;
         active_reg <= 1'b0;
      end else begin
         case (state_reg)
            S_CONV: begin
               oe_n_reg   <= 1'b0;
               active_reg <= 1'b1;
               if (bit_cnt_reg == 4'h0 && !active_reg) dout_reg <= 1'b0;
               else dout_reg <= sar_reg[3'(4'h8 - bit_cnt_reg)];
            end
            S_LSB: begin
               active_reg <= 1'b0;
               dout_reg   <= shift_reg[0];
            end
            S_DONE: begin
               active_reg <= 1'b0;
               dout_reg   <= 1'b0;
            end
            default: begin
               oe_n_reg   <= 1'b1;
               active_reg <= 1'b0;
            end
         endcase
      end
   end

   assign link.dout                   = dout_reg;
   assign link.dout_oe_n              = oe_n_reg;
   assign link.conversion_active_flag = active_reg;
   assign result                      = sar_reg;
endmodule
`default_nettype wire

// ==== logic/sadc_host.sv ====
`timescale 1ns/1ps
`default_nettype none
// Host end: runs one conversion per request
module sadc_host #(
   parameter int unsigned AW       = 4,
   parameter int unsigned NBITS    = 16,
   parameter int unsigned HALF_CYC = sadc_pkg::LINK_HALF_CYC
) (
   // Clock and reset
   input  wire logic          clock,
   input  wire logic          rst,
   // Link
   sadc_if.host               link,
   // User request
   input  wire logic          start,
   input  wire logic [3:0]    addr_word,
   input  wire logic          hold_lsb,
   output logic               busy,
   output logic               done,
   output logic [15:0]        rx_data
);
   initial begin
      if (AW > 4 || NBITS > 16 || NBITS < 9) $error("sadc_host: bad parameters");
      // Sync latency needs three host clocks per half period; gap count fits six bits
      if (HALF_CYC < 3 || HALF_CYC > 256 || sadc_pkg::IDLE_CLEAR_CYC > 62)
         $error("sadc_host: bad divider or gap");
   end

   typedef enum logic [1:0] {H_IDLE, H_RUN, H_GAP} sadc_hstate_e;

   sadc_hstate_e state_reg;
   logic [7:0]   div_reg;
   logic         sclk_reg;
   logic         cs_n_reg;
   logic         di_reg;
   logic [4:0]   tx_reg;
   logic [5:0]   edge_cnt_reg;
   logic [15:0]  rx_reg;
   logic         busy_reg;
   logic         done_reg;
   logic         dout_s;
   logic         flag_s;

   // Bring device outputs into this domain
   sadc_sync #(.W(2)) u_sync (
      .clock (clock),
      .rst   (rst),
      .d     ({link.dout, link.conversion_active_flag}),
      .q     ({dout_s, flag_s})
   );

   wire half_tick = (div_reg == 8'(HALF_CYC - 1));
   wire gap_end   = (edge_cnt_reg == 6'(sadc_pkg::IDLE_CLEAR_CYC));
   wire rise_tick = half_tick && !sclk_reg && state_reg == H_RUN;
   wire fall_tick = half_tick && sclk_reg;
   wire last_edge = (edge_cnt_reg == 6'(AW + 2 + NBITS));

   // Divider, link and state control
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_reg    <= H_IDLE;
         div_reg      <= 8'h00;
         sclk_reg     <= 1'b0;
         cs_n_reg     <= 1'b1;
         di_reg       <= 1'b0;
         tx_reg       <= 5'h00;
         edge_cnt_reg <= 6'h00;
         rx_reg       <= 16'h0000;
         busy_reg     <= 1'b0;
         done_reg     <= 1'b0;
      end else begin
         done_reg <= 1'b0;
         div_reg  <= half_tick ? 8'h00 : div_reg + 8'h01;
         case (state_reg)
            H_IDLE: begin
               if (start) begin
                  state_reg    <= H_RUN;
                  cs_n_reg     <= 1'b0;
                  tx_reg       <= {1'b1, addr_word};
                  di_reg       <= 1'b0;
                  edge_cnt_reg <= 6'h00;
                  busy_reg     <= 1'b1;
                  div_reg      <= 8'h00;
               end
            end
            H_RUN: begin
               if (half_tick) sclk_reg <= ~sclk_reg;
               if (fall_tick) begin
                  di_reg <= tx_reg[4];
                  tx_reg <= {tx_reg[3:0], 1'b0};
               end
               if (rise_tick) begin
                  edge_cnt_reg <= edge_cnt_reg + 6'h01;
                  if (edge_cnt_reg > 6'(AW + 1)) rx_reg <= {rx_reg[14:0], dout_s};
                  if (last_edge) begin
                     state_reg    <= H_GAP;
                     edge_cnt_reg <= 6'h00;
                  end
               end
            end
            H_GAP: begin
               sclk_reg     <= 1'b0;
               cs_n_reg     <= 1'b1;
               edge_cnt_reg <= edge_cnt_reg + 6'h01;
               // Deselect held for the idle clear time before done
               if (gap_end) begin
                  state_reg <= H_IDLE;
                  busy_reg  <= 1'b0;
                  done_reg  <= 1'b1;
               end
            end
            default: state_reg <= H_IDLE;
         endcase
      end
   end

   assign link.sclk             = sclk_reg;
   assign link.cs_n             = cs_n_reg;
   assign link.serial_in_line   = di_reg;
   assign link.lsb_shift_enable = hold_lsb;
   assign busy                  = busy_reg;
   assign done                  = done_reg;
   assign rx_data               = rx_reg;
   wire unused_flag = flag_s;
endmodule
`default_nettype wire

// ==== logic/sadc_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
// Two-flop level synchroniser
module sadc_sync #(
   parameter int unsigned W = 1
) (
   // Clock and reset
   input  wire logic         clock,
   input  wire logic         rst,
   // Data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_reg;

   // First stage feeds only the second
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         meta_reg <= '0;
         q        <= '0;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// ==== verif/sadc_props.sv ====
`timescale 1ns/1ps
`default_nettype none
// Link-side checks on the serial interface
module sadc_props (
   // Link clock and select
   input wire logic sclk,
   input wire logic cs_n,
   // Link data and status
   input wire logic serial_in_line,
   input wire logic dout,
   input wire logic dout_oe_n,
   input wire logic lsb_shift_enable,
   input wire logic conversion_active_flag
);
   logic [4:0] rise_cnt;
   // Rising link edges since selection
   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         rise_cnt <= 5'h00;
      end else if (rise_cnt != 5'h1F) begin
         rise_cnt <= rise_cnt + 5'h01;
      end
   end
   // Deselected state seen at each selection
   AST_DESEL_OE: assert property (@(negedge cs_n) dout_oe_n)
      else $error("output driven while deselected");
   AST_DESEL_CLR: assert property (@(negedge cs_n) !conversion_active_flag)
      else $error("flag not cleared by deselect");
   // Addressing and settling slot
   AST_ADDR_HIZ: assert property (@(posedge sclk) disable iff (cs_n)
      rise_cnt < 5'h06 |-> dout_oe_n && !conversion_active_flag)
      else $error("output driven during addressing");
   AST_ADDR_LEN: assert property (@(posedge sclk) disable iff (cs_n)
      $rose(conversion_active_flag) |-> rise_cnt == 5'h06)
      else $error("conversion began after wrong bit count");
   AST_LEAD_ZERO: assert property (@(posedge sclk) disable iff (cs_n)
      $rose(conversion_active_flag) |-> !dout_oe_n && !dout)
      else $error("no leading low bit");
   AST_OE_WITH_FLAG: assert property (@(posedge sclk) disable iff (cs_n)
      $fell(dout_oe_n) |-> $rose(conversion_active_flag))
      else $error("output enabled apart from conversion start");
   // Conversion length and output hold
   AST_CONV_LEN: assert property (@(posedge sclk) disable iff (cs_n)
      $rose(conversion_active_flag) |-> conversion_active_flag [*8] ##[1:3]
      !conversion_active_flag)
      else $error("conversion length wrong");
   AST_DRIVE_HOLD: assert property (@(posedge sclk) disable iff (cs_n)
      $fell(dout_oe_n) |-> !dout_oe_n [*8])
      else $error("output released during result");
   AST_SE_HOLD: assert property (@(posedge sclk) disable iff (cs_n)
      !conversion_active_flag && !$past(conversion_active_flag) && !dout_oe_n
      && !$past(dout_oe_n) && lsb_shift_enable && $past(lsb_shift_enable)
      |-> $stable(dout))
      else $error("output moved while shift held");
   // Main scenarios
   COV_START: cover property (@(posedge sclk) disable iff (cs_n) $rose(conversion_active_flag));
   COV_END: cover property (@(posedge sclk) disable iff (cs_n) $fell(conversion_active_flag));
   COV_HOLD: cover property (@(posedge sclk) disable iff (cs_n)
      !conversion_active_flag && !dout_oe_n && lsb_shift_enable);
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int LIMIT = 10000;
   logic       clock;
   logic       rst;
   logic       start;
   logic [3:0] addr_word;
   logic       hold_lsb;
   logic [7:0] comparator_in;
   logic       busy;
   logic       done;
   logic [15:0] rx_data;
   logic [2:0] pos_ch;
   logic [2:0] neg_ch;
   logic       neg_com;
   logic [7:0] result;
   int         n_errors;
   int         n_checks;
   int         cycles;
   sadc_if link_if ();
   // Two ends facing each other
   sadc_host #(.AW(4), .NBITS(16), .HALF_CYC(4)) u_sadc_host (.clock(clock), .rst(rst),
      .link(link_if),
      .start(start), .addr_word(addr_word), .hold_lsb(hold_lsb), .busy(busy), .done(done),
      .rx_data(rx_data));
   sadc_dev #(.CHANNELS(sadc_pkg::CH8), .HAS_SE(1'b1)) u_sadc_dev (.link(link_if),
      .comparator_in(comparator_in), .pos_channel(pos_ch), .neg_channel(neg_ch),
      .neg_is_common(neg_com), .result(result));
   sadc_props u_sadc_props (.sclk(link_if.sclk), .cs_n(link_if.cs_n),
      .serial_in_line(link_if.serial_in_line), .dout(link_if.dout),
      .dout_oe_n(link_if.dout_oe_n), .lsb_shift_enable(link_if.lsb_shift_enable),
      .conversion_active_flag(link_if.conversion_active_flag));
   // Clock and hang guard
   always #5 clock = ~clock;
   always @(posedge clock) begin
      cycles++;
      if (cycles >= LIMIT) begin
         n_errors++;
         conclude();
      end
   end
   task automatic conclude();
      if (n_errors == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One conversion; poke tries a second start while busy
   task automatic convert(input logic [3:0] aw, input logic [7:0] cmp, input logic hold,
                          input logic poke);
      int          k;
      logic [15:0] exp;
      @(posedge clock) #1;
      addr_word = aw;
      comparator_in = cmp;
      hold_lsb = hold;
      start = 1'b1;
      @(posedge clock) #1;
      start = 1'b0;
      for (k = 0; k < 5000 && link_if.conversion_active_flag !== 1'b1; k++) @(posedge clock) #1;
      if (k >= 5000) n_errors++;
      if (poke) begin
         addr_word = ~aw;
         start = 1'b1;
         @(posedge clock) #1;
         start = 1'b0;
      end
      check({13'h0000, pos_ch}, {13'h0000, aw[1:0], aw[2]});
      check({15'h0000, neg_com}, {15'h0000, aw[3]});
      if (!aw[3]) begin
         check({13'h0000, neg_ch}, {13'h0000, aw[1:0], ~aw[2]});
      end
      for (k = 0; k < 5000 && done !== 1'b1; k++) @(posedge clock) #1;
      if (k >= 5000) n_errors++;
      check({8'h00, result}, 16'h0000);
      exp = {cmp, 8'h00};
      for (int i = 1; i < 8; i++) begin
         exp[8 - i] = hold ? cmp[0] : cmp[i];
      end
      if (hold) begin
         check({rx_data[15:1], 1'b0}, exp);
      end else begin
         check(rx_data, exp);
      end
   endtask
   // Reset, then every address word, a refused start and a held shift
   initial begin
      clock = 1'b0;
      rst = 1'b1;
      start = 1'b0;
      addr_word = 4'h0;
      hold_lsb = 1'b0;
      comparator_in = 8'h00;
      n_errors = 0;
      n_checks = 0;
      cycles = 0;
      repeat (3) @(posedge clock);
      #1;
      rst = 1'b0;
      for (int a = 0; a < 16; a++) begin
         convert(a[3:0], {a[3:0], ~a[3:0]} ^ 8'h5A, 1'b0, a == 5);
      end
      convert(4'hB, 8'hC3, 1'b1, 1'b0);
      conclude();
   end
endmodule
`default_nettype wire
